// ---- hdl/lhcd_serial_rx.sv ----
// serial byte receiver working on filtered pin levels
`timescale 1ns/1ps
module lhcd_serial_rx
   import lhcd_pkg::*;
(
   input  wire logic       clock_in,
   input  wire logic       rst_n_in,
   input  wire logic       enable_in,
   input  wire logic       chip_select_n_in,
   input  wire logic       cmd_data_select_in,
   input  wire logic       shift_clock_in,
   input  wire logic       serial_data_in,
   output lhcd_pkg::lhcd_byte_t byte_out
);
   import lhcd_pkg::*;

   logic       shift_clock_q;
   logic [2:0] bit_count;
   logic [6:0] shifter;
   logic       shift_rise;

   assign shift_rise = enable_in & ~chip_select_n_in & ~shift_clock_q & shift_clock_in;

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         // same level as the synchroniser reset, so no false edge after reset
         shift_clock_q <= 1'b1;
      end else begin
         shift_clock_q <= shift_clock_in;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bit_count <= 3'h0;
         shifter   <= 7'h00;
      end else if (chip_select_n_in || !enable_in) begin
         bit_count <= 3'h0;
      end else if (shift_rise) begin
         bit_count <= bit_count + 3'h1;
         shifter   <= {shifter[5:0], serial_data_in};
      end
   end

   // msb first, select at bit eight
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         byte_out <= '0;
      end else begin
         byte_out.valid <= shift_rise && (bit_count == 3'h7);
         if (shift_rise && (bit_count == 3'h7)) begin
            byte_out.is_data <= cmd_data_select_in;
            byte_out.value   <= {shifter, serial_data_in};
         end
      end
   end

endmodule : lhcd_serial_rx

// ---- hdl/lhcd_sync.sv ----
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module lhcd_sync #(
   parameter int             W    = 1,
   parameter logic [W-1:0]   INIT = '0
) (
   input  wire logic         clock_in,
   input  wire logic         rst_n_in,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] level_out
);
   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stage1 <= INIT;
         stage2 <= INIT;
         stage3 <= INIT;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // a bit only moves once the second and third stage agree
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         level_out <= INIT;
      end else begin
         level_out <= (stage3 & ~(stage2 ^ stage3)) | (level_out & (stage2 ^ stage3));
      end
   end

endmodule : lhcd_sync

// ---- hdl/lhcd_top.sv ----
// display command decoder with parallel and serial host ports and display RAM
`timescale 1ns/1ps
`include "lhcd_map.svh"
module lhcd_top
   import lhcd_pkg::*;
(
   input  wire logic       clock_in,
   input  wire logic       rst_n_in,
   input  wire logic       parallel_sel_in,
   input  wire logic       chip_select_n_in,
   input  wire logic       cmd_data_select_in,
   input  wire logic       wr_n_in,
   input  wire logic       rd_n_in,
   input  wire logic [7:0] data_in,
   output logic      [7:0] data_out,
   output logic            data_oe_out,
   output logic            display_on_out,
   output logic      [5:0] start_line_out,
   output logic            seg_reverse_out,
   output logic      [3:0] page_out,
   output logic      [7:0] column_out,
   output logic            busy_out
);
   import lhcd_pkg::*;

   localparam logic [8:0]  INIT_CYC  = 9'(`LHCD_INIT_CYC);
   localparam logic [3:0]  PAGE_LAST = 4'(`LHCD_PAGES - 1);
   localparam int          DEPTH     = `LHCD_RAM_DEPTH;

   lhcd_pins_t  pins_raw;
   lhcd_pins_t  pins;
   lhcd_byte_t  par_byte;
   lhcd_byte_t  ser_byte;
   lhcd_byte_t  host_byte;
   lhcd_state_t state;

   logic [8:0]  init_count;
   logic        wr_n_q;
   logic        rd_n_q;
   logic        cs_n_q;
   logic        rd_is_data;
   logic        rd_active;
   logic        rd_end;
   logic        wr_rise;
   logic        accept;
   logic        cmd_ev;
   logic        data_wr_ev;
   logic        data_rd_ev;
   logic [7:0]  phys_col;
   logic [10:0] ram_index;
   logic        addr_ok;
   logic [7:0]  ram_q;
   logic [7:0]  status;
   logic [7:0]  ram [0:DEPTH-1];

   assign pins_raw = '{parallel_sel    : parallel_sel_in,
                       chip_select_n   : chip_select_n_in,
                       cmd_data_select : cmd_data_select_in,
                       wr_n            : wr_n_in,
                       rd_n            : rd_n_in,
                       bus             : data_in};

   lhcd_sync #(
      .W    (13),
      .INIT (`LHCD_PIN_RESET)
   ) u_pin_sync (
      .clock_in  (clock_in),
      .rst_n_in  (rst_n_in),
      .async_in  (pins_raw),
      .level_out (pins)
   );

   // serial port on two bus pins
   lhcd_serial_rx u_serial (
      .clock_in           (clock_in),
      .rst_n_in           (rst_n_in),
      .enable_in          (~pins.parallel_sel),
      .chip_select_n_in   (pins.chip_select_n),
      .cmd_data_select_in (pins.cmd_data_select),
      .shift_clock_in     (pins.bus[6]),
      .serial_data_in     (pins.bus[7]),
      .byte_out           (ser_byte)
   );

   // power-up interval during which the reset flag stays set
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state      <= LHCD_INIT;
         init_count <= 9'h000;
      end else begin
         case (state)
            LHCD_INIT: begin
               if (init_count == INIT_CYC - 9'h001) begin
                  state <= LHCD_READY;
               end else begin
                  init_count <= init_count + 9'h001;
               end
            end
            LHCD_READY: begin
               state <= LHCD_READY;
            end
            default: begin
               state <= LHCD_INIT;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_n_q <= 1'b1;
         rd_n_q <= 1'b1;
         cs_n_q <= 1'b1;
      end else begin
         wr_n_q <= pins.wr_n;
         rd_n_q <= pins.rd_n;
         cs_n_q <= pins.chip_select_n;
      end
   end

   assign rd_active = pins.parallel_sel & ~pins.chip_select_n & ~pins.rd_n;
   assign wr_rise   = pins.parallel_sel & ~cs_n_q & ~wr_n_q & pins.wr_n;
   assign rd_end    = pins.parallel_sel & ~cs_n_q & ~rd_n_q & pins.rd_n;

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         par_byte <= '0;
      end else begin
         par_byte.valid <= wr_rise;
         if (wr_rise) begin
            par_byte.is_data <= pins.cmd_data_select;
            par_byte.value   <= pins.bus;
         end
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_is_data <= 1'b0;
      end else if (rd_active) begin
         rd_is_data <= pins.cmd_data_select;
      end
   end

   assign host_byte  = pins.parallel_sel ? par_byte : ser_byte;
   // bytes count only once busy has dropped at the port, as the host sees it
   assign accept     = host_byte.valid & ~busy_out;
   assign cmd_ev     = accept & ~host_byte.is_data;
   assign data_wr_ev = accept & host_byte.is_data;
   assign data_rd_ev = rd_end & rd_is_data & ~busy_out;

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         display_on_out <= 1'b0;
      end else if (cmd_ev && (host_byte.value ==? `LHCD_CMD_DISP)) begin
         display_on_out <= host_byte.value[0];
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         start_line_out <= 6'h00;
      end else if (cmd_ev && (host_byte.value ==? `LHCD_CMD_START)) begin
         start_line_out <= host_byte.value[5:0];
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         page_out <= 4'h0;
      end else if (cmd_ev && (host_byte.value ==? `LHCD_CMD_PAGE)) begin
         page_out <= host_byte.value[3:0];
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         seg_reverse_out <= 1'b0;
      end else if (cmd_ev && (host_byte.value ==? `LHCD_CMD_ADC)) begin
         seg_reverse_out <= host_byte.value[0];
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         column_out <= 8'h00;
      end else if (cmd_ev && (host_byte.value ==? `LHCD_CMD_COL_HI)) begin
         column_out <= {host_byte.value[3:0], column_out[3:0]};
      end else if (cmd_ev && (host_byte.value ==? `LHCD_CMD_COL_LO)) begin
         column_out <= {column_out[7:4], host_byte.value[3:0]};
      end else if (data_wr_ev || data_rd_ev) begin
         column_out <= column_out + 8'h01;
      end
   end

   // reversed order maps column from the far end
   assign phys_col  = seg_reverse_out ? (`LHCD_LAST_COLUMN - column_out) : column_out;
   assign addr_ok   = (page_out <= PAGE_LAST) && (column_out <= `LHCD_LAST_COLUMN);
   assign ram_index = 11'({page_out, 7'h00}) + 11'({page_out, 2'h0}) + 11'(phys_col);

   always_ff @(posedge clock_in) begin
      if (data_wr_ev && addr_ok) begin
         ram[ram_index] <= host_byte.value;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ram_q <= 8'h00;
      end else begin
         ram_q <= addr_ok ? ram[ram_index] : 8'h00;
      end
   end

   always_comb begin
      status                 = 8'h00;
      status[`LHCD_ST_BUSY]  = (state == LHCD_INIT);
      status[`LHCD_ST_ADC]   = seg_reverse_out;
      status[`LHCD_ST_ON]    = display_on_out;
      status[`LHCD_ST_RESET] = (state == LHCD_INIT);
   end

   // bus driven while read strobe and chip select low in parallel mode
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         data_out    <= 8'h00;
         data_oe_out <= 1'b0;
      end else begin
         data_oe_out <= rd_active;
         if (rd_active) begin
            data_out <= pins.cmd_data_select ? ram_q : status;
         end
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         busy_out <= 1'b1;
      end else begin
         busy_out <= (state == LHCD_INIT);
      end
   end

endmodule : lhcd_top

// ---- pkg/lhcd_map.svh ----
// constants of the display command decoder
`ifndef LHCD_MAP_SVH
`define LHCD_MAP_SVH

`define LHCD_CLK_NS       20
`define LHCD_INIT_NS      10000
`define LHCD_INIT_CYC     ((`LHCD_INIT_NS + `LHCD_CLK_NS - 1) / `LHCD_CLK_NS)

`define LHCD_PAGES        9
`define LHCD_COLUMNS      132
`define LHCD_LAST_COLUMN  8'h83
`define LHCD_RAM_DEPTH    (`LHCD_PAGES * `LHCD_COLUMNS)

`define LHCD_CMD_DISP     8'b1010_111?
`define LHCD_CMD_START    8'b01??_????
`define LHCD_CMD_PAGE     8'b1011_????
`define LHCD_CMD_COL_HI   8'b0001_????
`define LHCD_CMD_COL_LO   8'b0000_????
`define LHCD_CMD_ADC      8'b1010_000?

`define LHCD_ST_BUSY      7
`define LHCD_ST_ADC       6
`define LHCD_ST_ON        5
`define LHCD_ST_RESET     4

`define LHCD_PIN_RESET    13'h1FFF

`endif

// ---- pkg/lhcd_pkg.sv ----
// types shared by the display command decoder
package lhcd_pkg;

   typedef struct packed {
      logic       valid;
      logic       is_data;
      logic [7:0] value;
   } lhcd_byte_t;

   typedef struct packed {
      logic       parallel_sel;
      logic       chip_select_n;
      logic       cmd_data_select;
      logic       wr_n;
      logic       rd_n;
      logic [7:0] bus;
   } lhcd_pins_t;

   typedef enum logic [0:0] {
      LHCD_INIT  = 1'b0,
      LHCD_READY = 1'b1
   } lhcd_state_t;

endpackage : lhcd_pkg

// ---- tb/lcd_host_command_decoder_tb_top.sv ----
// self-checking bench for the display command decoder
`timescale 1ns/1ps
module lcd_host_command_decoder_tb_top;
   import lhcd_pkg::*;
   logic       clock_in;
   logic       rst_n_in;
   lhcd_pins_t pins;
   logic [7:0] data_out;
   logic       data_oe_out, display_on_out, seg_reverse_out, busy_out, oe;
   logic [5:0] start_line_out;
   logic [3:0] page_out;
   logic [7:0] column_out, got, exp_b;
   logic [7:0] mem [3];
   int         n_mismatch, compares, seed, col, pg;
   lhcd_top u_lhcd_top (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .parallel_sel_in(pins.parallel_sel), .chip_select_n_in(pins.chip_select_n),
      .cmd_data_select_in(pins.cmd_data_select), .wr_n_in(pins.wr_n), .rd_n_in(pins.rd_n),
      .data_in(data_oe_out ? data_out : pins.bus), .data_out(data_out),
      .data_oe_out(data_oe_out), .display_on_out(display_on_out),
      .start_line_out(start_line_out), .seg_reverse_out(seg_reverse_out),
      .page_out(page_out), .column_out(column_out), .busy_out(busy_out));
   lhcd_host u_lhcd_host (.clock_in(clock_in), .rd_data_in(data_out), .rd_oe_in(data_oe_out),
      .pins_out(pins));
   initial begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end
   function automatic logic [7:0] st(input logic on, input logic adc);
      return {1'b0, adc, on, 5'h00};
   endfunction : st
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic set_col(input logic [7:0] c, input logic hi_first);
      if (hi_first) u_lhcd_host.wr(1'b0, {4'h1, c[7:4]}, 1'b0);
      u_lhcd_host.wr(1'b0, {4'h0, c[3:0]}, 1'b0);
      if (!hi_first) u_lhcd_host.wr(1'b0, {4'h1, c[7:4]}, 1'b0);
   endtask : set_col
   task automatic stop_test;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   initial begin
      repeat (30000) @(posedge clock_in);
      n_mismatch++;
      $display("MISMATCH watchdog expected done seen timeout");
      stop_test();
   end
   initial begin
      seed = 69222;
      n_mismatch = 0;
      compares = 0;
      rst_n_in = 1'b0;
      repeat (4) @(negedge clock_in);
      rst_n_in = 1'b1;
      repeat (10) @(negedge clock_in);
      u_lhcd_host.rd(1'b0, got, oe);
      chk("status_busy", 8'h90, got);
      u_lhcd_host.wr(1'b0, 8'hAF, 1'b0);
      chk("busy_drop", 8'h00, {7'h00, display_on_out});
      $display("busy phase test done");
      repeat (480) @(negedge clock_in);
      u_lhcd_host.rd(1'b0, got, oe);
      chk("status_init", st(1'b0, 1'b0), got);
      for (int i = 0; i < 4; i++) begin
         u_lhcd_host.wr(1'b0, {7'h57, i[0] ~^ i[1]}, i[0]);
         chk("display_on", {7'h00, ~i[1]}, {7'h00, display_on_out});
         u_lhcd_host.rd(1'b0, got, oe);
         chk("status_on", st(~i[1], 1'b0), got);
      end
      $display("display on and off test done");
      for (int i = 0; i < 4; i++) begin
         exp_b = (i < 2) ? {2'b00, {6{i[0]}}} : 8'($random(seed));
         u_lhcd_host.wr(1'b0, {2'b01, exp_b[5:0]}, 1'b0);
         chk("start_line", {2'b00, exp_b[5:0]}, {2'b00, start_line_out});
      end
      $display("start line test done");
      for (int i = 0; i < 2; i++) begin
         u_lhcd_host.wr(1'b0, {7'h50, ~i[0]}, 1'b0);
         chk("seg_reverse", {7'h00, ~i[0]}, {7'h00, seg_reverse_out});
         u_lhcd_host.rd(1'b0, got, oe);
         chk("status_adc", st(1'b0, ~i[0]), got);
      end
      $display("segment order test done");
      for (int i = 0; i < 3; i++) begin
         pg = (i == 0) ? 8 : $unsigned($random(seed)) % 9;
         col = (i == 0) ? 128 : $unsigned($random(seed)) % 129;
         u_lhcd_host.wr(1'b0, {4'hB, 4'(pg)}, 1'b0);
         set_col(8'(col), i[0]);
         chk("page", 8'(pg), {4'h0, page_out});
         chk("column", 8'(col), column_out);
         for (int k = 0; k < 3; k++) begin
            mem[k] = (k == 0) ? 8'hAF : 8'($random(seed));
            u_lhcd_host.wr(1'b1, mem[k], 1'b0);
         end
         chk("column_wr", 8'(col + 3), column_out);
         chk("display_data", 8'h00, {7'h00, display_on_out});
         set_col(8'(col), ~i[0]);
         for (int k = 0; k < 3; k++) begin
            u_lhcd_host.rd(1'b1, got, oe);
            chk("ram_byte", mem[k], got);
         end
         chk("column_rd", 8'(col + 3), column_out);
      end
      $display("display data test done");
      u_lhcd_host.mode(1'b0);
      pg = $unsigned($random(seed)) % 9;
      u_lhcd_host.ser(1'b0, {4'hB, 4'(pg)});
      chk("ser_page", 8'(pg), {4'h0, page_out});
      u_lhcd_host.ser(1'b0, 8'h10);
      u_lhcd_host.ser(1'b0, 8'h05);
      exp_b = 8'($random(seed));
      u_lhcd_host.ser(1'b1, exp_b);
      chk("ser_column", 8'h06, column_out);
      u_lhcd_host.rd(1'b0, got, oe);
      chk("ser_no_read", 8'h00, {7'h00, oe});
      u_lhcd_host.mode(1'b1);
      set_col(8'h05, 1'b1);
      u_lhcd_host.rd(1'b1, got, oe);
      chk("ser_ram", exp_b, got);
      u_lhcd_host.wr(1'b0, 8'hA1, 1'b0);
      set_col(8'h7E, 1'b0);
      u_lhcd_host.rd(1'b1, got, oe);
      chk("rev_ram", exp_b, got);
      $display("serial test done");
      stop_test();
   end
endmodule : lcd_host_command_decoder_tb_top

// ---- tb/lhcd_chk.sv ----
// port assertions for the display command decoder
`timescale 1ns/1ps
module lhcd_chk (
   input wire logic       clock_in,
   input wire logic       rst_n_in,
   input wire logic       parallel_sel_in,
   input wire logic       chip_select_n_in,
   input wire logic       cmd_data_select_in,
   input wire logic       rd_n_in,
   input wire logic [7:0] data_out,
   input wire logic       data_oe_out,
   input wire logic       display_on_out,
   input wire logic [5:0] start_line_out,
   input wire logic       seg_reverse_out,
   input wire logic [3:0] page_out,
   input wire logic [7:0] column_out,
   input wire logic       busy_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);
   wire [19:0] ctrl = {display_on_out, start_line_out, seg_reverse_out, page_out, column_out};
   sequence s_rd_idle;
      rd_n_in [*8];
   endsequence
   sequence s_cs_idle;
      chip_select_n_in [*8];
   endsequence
   sequence s_status;
      (!cmd_data_select_in) [*8] ##0 data_oe_out;
   endsequence
   a_busy_hold: assert property ($rose(rst_n_in) |-> busy_out [*8])
      else $error("busy dropped too early after reset");
   a_busy_freeze: assert property (busy_out |=> $stable(ctrl))
      else $error("control changed while busy");
   a_idle_frozen: assert property (s_cs_idle |-> $stable(ctrl))
      else $error("control changed without chip select");
   a_oe_needs_rd: assert property (s_rd_idle |-> !data_oe_out)
      else $error("bus driven without read strobe");
   a_oe_needs_cs: assert property (s_cs_idle |-> !data_oe_out)
      else $error("bus driven without chip select");
   a_oe_not_serial: assert property ((!parallel_sel_in) [*8] |-> !data_oe_out)
      else $error("bus driven in serial mode");
   a_status_low_zero: assert property (s_status |-> data_out[3:0] == 4'h0)
      else $error("status low nibble not zero");
   a_status_on_bit: assert property (s_status |-> data_out[5] == display_on_out)
      else $error("status on bit wrong");
   a_status_adc_bit: assert property (s_status |-> data_out[6] == seg_reverse_out)
      else $error("status direction bit wrong");
   a_status_busy_bit: assert property (s_status |-> data_out[7] == busy_out)
      else $error("status busy bit wrong");
endmodule : lhcd_chk
bind lhcd_top lhcd_chk u_lhcd_chk (
   .clock_in           (clock_in),
   .rst_n_in           (rst_n_in),
   .parallel_sel_in    (parallel_sel_in),
   .chip_select_n_in   (chip_select_n_in),
   .cmd_data_select_in (cmd_data_select_in),
   .rd_n_in            (rd_n_in),
   .data_out           (data_out),
   .data_oe_out        (data_oe_out),
   .display_on_out     (display_on_out),
   .start_line_out     (start_line_out),
   .seg_reverse_out    (seg_reverse_out),
   .page_out           (page_out),
   .column_out         (column_out),
   .busy_out           (busy_out)
);

// ---- tb/lhcd_host.sv ----
// host processor model driving the decoder pins
`timescale 1ns/1ps
module lhcd_host
   import lhcd_pkg::*;
(
   input  wire logic [7:0]      rd_data_in,
   input  wire logic            rd_oe_in,
   input  wire logic            clock_in,
   output lhcd_pkg::lhcd_pins_t pins_out
);
   lhcd_pins_t p;
   assign pins_out = p;
   initial p = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 8'hFF};
   task automatic idle(input int n);
      repeat (n) @(negedge clock_in);
   endtask : idle
   task automatic mode(input logic par);
      idle(1);
      p.parallel_sel = par;
      p.bus = par ? 8'hFF : 8'h3F;
      idle(10);
   endtask : mode
   task automatic wr(input logic cd, input logic [7:0] b, input logic cs_n);
      idle(1);
      p.chip_select_n = cs_n;
      p.cmd_data_select = cd;
      p.bus = b;
      idle(5);
      p.wr_n = 1'b0;
      idle(6);
      p.wr_n = 1'b1;
      idle(6);
      p.chip_select_n = 1'b1;
      p.bus = ~b;
      idle(6);
   endtask : wr
   task automatic rd(input logic cd, output logic [7:0] b, output logic oe);
      idle(1);
      p.chip_select_n = 1'b0;
      p.cmd_data_select = cd;
      idle(5);
      p.rd_n = 1'b0;
      idle(10);
      b = rd_data_in;
      oe = rd_oe_in;
      p.rd_n = 1'b1;
      idle(8);
      p.chip_select_n = 1'b1;
      idle(4);
   endtask : rd
   // msb first, select held past bit eight
   task automatic ser(input logic cd, input logic [7:0] b);
      idle(1);
      p.chip_select_n = 1'b0;
      p.cmd_data_select = cd;
      for (int i = 7; i >= 0; i--) begin
         p.bus = {b[i], 1'b0, 6'h3F};
         idle(6);
         p.bus[6] = 1'b1;
         idle(6);
      end
      p.bus[6] = 1'b0;
      idle(6);
      p.chip_select_n = 1'b1;
      p.bus[7] = ~b[0];
      idle(6);
   endtask : ser
endmodule : lhcd_host
